// ---- core/spi_front_pkg.sv ----
// Constants shared by the serial slave front end and its helpers.
// Assumes a single system clock domain into which all pins are synchronised.
`default_nettype none

package spi_front_pkg;

   localparam int unsigned WORD_BITS  = 16;
   localparam int unsigned FRAME_MIN  = 16;
   localparam int unsigned MOD_STEP   = 8;
   localparam int unsigned CNT_W      = 5;
   localparam int unsigned SYNC_BITS  = 3;

   localparam logic [CNT_W-1:0]     CNT_RST   = 5'h00;
   localparam logic [CNT_W-1:0]     CNT_FULL  = 5'h10;
   localparam logic [CNT_W-1:0]     CNT_WRAP  = 5'h17;
   localparam logic [CNT_W-1:0]     CNT_ONE   = 5'h01;

   localparam int unsigned          SYNC_CS   = 2;
   localparam int unsigned          SYNC_SCLK = 1;
   localparam int unsigned          SYNC_SI   = 0;
   localparam logic [SYNC_BITS-1:0] SYNC_RST  = 3'h4;

   localparam logic [WORD_BITS-1:0] SHIFT_RST = 16'h0000;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_XFER,
      ST_BLOCKED
   } link_state_t;

endpackage : spi_front_pkg

`default_nettype wire

// ---- core/spi_core_if.sv ----
// Internal carrier between the front end, its pin synchroniser and its frame counter.
// Assumes all members live in the system clock domain.
`default_nettype none

interface spi_core_if;
   logic cs_n_s;
   logic sclk_s;
   logic si_s;
   logic start;
   logic sample;
   logic frame_ok;

   modport sync_mp (output cs_n_s, output sclk_s, output si_s);
   modport cnt_mp  (input start, input sample, output frame_ok);
   modport top_mp  (input cs_n_s, input sclk_s, input si_s, input frame_ok, output start, output sample);
endinterface : spi_core_if

`default_nettype wire

// ---- core/spi_pin_sync.sv ----
// Two flip-flop synchroniser for chip select, serial clock and serial input.
// Assumes the pins are asynchronous to the system clock.
`default_nettype none

module spi_pin_sync
   import spi_front_pkg::*;
(
   // Clock and reset.
   input  wire logic                 i_clk,
   input  wire logic                 i_rst_n,
   // Raw pins.
   input  wire logic [SYNC_BITS-1:0] i_raw,
   // Synchronised levels.
   spi_core_if.sync_mp               sync
);

   wire logic [SYNC_BITS-1:0] stab;

   // Each pin owns its flip-flops, so no register is written by more than one process.
   genvar g;
   generate
      for (g = 0; g < SYNC_BITS; g++) begin : g_sync
         logic meta_q;
         logic stab_q;
         always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               meta_q <= SYNC_RST[g];
               stab_q <= SYNC_RST[g];
            end else begin
               meta_q <= i_raw[g];
               stab_q <= meta_q;
            end
         end
         assign stab[g] = stab_q;
      end
   endgenerate

   assign sync.cs_n_s = stab[SYNC_CS];
   assign sync.sclk_s = stab[SYNC_SCLK];
   assign sync.si_s   = stab[SYNC_SI];

endmodule : spi_pin_sync

`default_nettype wire

// ---- core/spi_frame_counter.sv ----
// Modulo 8/16 counter of sampling edges within one access.
// Assumes start and sample are single-cycle strobes from the front end.
`default_nettype none

module spi_frame_counter
   import spi_front_pkg::*;
(
   // Clock and reset.
   input  wire logic   i_clk,
   input  wire logic   i_rst_n,
   // Strobes in, verdict out.
   spi_core_if.cnt_mp  cnt
);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic             at_wrap;

   // After sixteen pulses the count cycles through 16..23, so 16 marks a whole frame.
   assign at_wrap = (cnt_q == CNT_WRAP);
   assign cnt_d   = cnt.start ? CNT_RST :
                    !cnt.sample ? cnt_q :
                    at_wrap ? CNT_FULL : cnt_q + CNT_ONE;
   assign cnt.frame_ok = (cnt_q == CNT_FULL);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q <= CNT_RST;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   property p_wrap;
      @(posedge i_clk) disable iff (!i_rst_n)
      (cnt.sample && !cnt.start && at_wrap) |=> (cnt_q == CNT_FULL);
   endproperty
   a_wrap: assert property (p_wrap) else $error("count did not wrap to sixteen");

   property p_restart;
      @(posedge i_clk) disable iff (!i_rst_n)
      cnt.start |=> (cnt_q == CNT_RST) && !cnt.frame_ok;
   endproperty
   a_restart: assert property (p_restart) else $error("count not cleared at access start");

endmodule : spi_frame_counter

`default_nettype wire

// ---- core/spi_slave_front.sv ----
// Sixteen-bit serial slave front end with daisy-chain frame checking.
// Assumes pins arrive asynchronously and are sampled by the system clock.
// Notes on behaviour
// - Chip select falling starts access, restarts count.
// - Serial input captured on serial clock falling.
// - Serial output changes on serial clock rising.
// - Accept sixteen plus multiple-of-eight pulses only.
// - Bad count sets error flag, discards command.
// - Chip select high: ignore inputs, output floats.
// - Data moves only while chip select low.
// - Chip select falling loads response into shifter.
// - Output starts as error flag OR input.
// - Sleep keeps output floating, no transfer.
// - Valid frame commits shifter at chip select rising.
// - Full duplex: receive and transmit together.
// - Most significant bit first, both directions.
// - One shift register: bit in, bit out.
`default_nettype none

module spi_slave_front
   import spi_front_pkg::*;
(
   // Clock and reset.
   input  wire logic                 I_SYS_CLK,
   input  wire logic                 I_RST_N,
   // Serial pins.
   input  wire logic                 I_CHIP_SELECT_N,
   input  wire logic                 I_SCLK,
   input  wire logic                 I_SI,
   output logic                      O_SO,
   output logic                      O_SO_OE,
   // Device side.
   input  wire logic                 I_SLEEP,
   input  wire logic [WORD_BITS-1:0] I_RESP_DATA,
   output logic [WORD_BITS-1:0]      O_CMD_DATA,
   output logic                      O_CMD_VALID,
   output logic                      O_TRANSMISSION_ERROR_FLAG
);

   spi_core_if core ();

   logic                 cs_prev_q;
   logic                 sclk_prev_q;
   link_state_t          state_q;
   link_state_t          state_d;
   logic [WORD_BITS-1:0] shift_q;
   logic [WORD_BITS-1:0] shift_d;
   logic                 so_q;
   logic                 so_d;
   logic                 lead_q;
   logic                 ter_q;
   logic                 ter_d;
   logic [WORD_BITS-1:0] cmd_q;
   logic                 cmd_valid_q;
   logic                 sclk_bad_q;

   logic cs_fall;
   logic cs_rise;
   logic sclk_fall;
   logic sclk_rise;
   logic in_xfer;
   logic commit;
   logic reject;
   logic sclk_high_at_cs;

   // The transfer state is tested in several places, so its decode lives in one function.
   function automatic logic is_xfer(input link_state_t s);
      return (s == ST_XFER);
   endfunction : is_xfer

   spi_pin_sync u_sync (
      .i_clk   (I_SYS_CLK),
      .i_rst_n (I_RST_N),
      .i_raw   ({I_CHIP_SELECT_N, I_SCLK, I_SI}),
      .sync    (core.sync_mp)
   );

   spi_frame_counter u_count (
      .i_clk   (I_SYS_CLK),
      .i_rst_n (I_RST_N),
      .cnt     (core.cnt_mp)
   );

   // Edges are found on synchronised levels only, so the serial clock must stay well below the system rate.
   assign cs_fall   = cs_prev_q && !core.cs_n_s;
   assign cs_rise   = !cs_prev_q && core.cs_n_s;
   assign in_xfer   = is_xfer(state_q) && !core.cs_n_s;
   assign sclk_fall = in_xfer && sclk_prev_q && !core.sclk_s;
   assign sclk_rise = in_xfer && !sclk_prev_q && core.sclk_s;

   // A select edge with the clock high makes the access suspect, so it is rejected.
   assign sclk_high_at_cs = (cs_fall || cs_rise) && core.sclk_s;
   assign commit = cs_rise && is_xfer(state_q) && core.frame_ok && !sclk_bad_q && !sclk_high_at_cs;
   assign reject = cs_rise && is_xfer(state_q) && !commit;

   assign core.start  = cs_fall;
   assign core.sample = sclk_fall;

   // Sleep is looked at only as an access starts, so raising it mid-access changes nothing.
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (cs_fall) begin
               state_d = I_SLEEP ? ST_BLOCKED : ST_XFER;
            end
         end
         ST_XFER, ST_BLOCKED: begin
            if (cs_rise) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // One register both receives and transmits, so only the last sixteen bits survive a long frame.
   assign shift_d = (cs_fall && !I_SLEEP) ? I_RESP_DATA :
                    sclk_fall ? {shift_q[WORD_BITS-2:0], core.si_s} :
                    shift_q;

   assign so_d = (cs_fall || (in_xfer && lead_q)) ? (ter_q | core.si_s) :
                 sclk_rise ? shift_q[WORD_BITS-1] :
                 so_q;

   // Setting wins over clearing, so a failed access is never hidden.
   assign ter_d = reject ? 1'b1 : commit ? 1'b0 : ter_q;

   always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         cs_prev_q   <= 1'b1;
         sclk_prev_q <= 1'b0;
         state_q     <= ST_IDLE;
      end else begin
         cs_prev_q   <= core.cs_n_s;
         sclk_prev_q <= core.sclk_s;
         state_q     <= state_d;
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         shift_q <= SHIFT_RST;
         so_q    <= 1'b0;
         ter_q   <= 1'b0;
      end else begin
         shift_q <= shift_d;
         so_q    <= so_d;
         ter_q   <= ter_d;
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         lead_q <= 1'b0;
      end else if (cs_fall) begin
         lead_q <= 1'b1;
      end else if (sclk_rise || cs_rise) begin
         lead_q <= 1'b0;
      end
   end

   // A clock-high start is only judged when the access ends, so its level is kept until then.
   always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         sclk_bad_q <= 1'b0;
      end else if (cs_fall) begin
         sclk_bad_q <= sclk_high_at_cs;
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         cmd_q       <= SHIFT_RST;
         cmd_valid_q <= 1'b0;
      end else begin
         cmd_valid_q <= commit;
         if (commit) begin
            cmd_q <= shift_q;
         end
      end
   end

   assign O_SO                      = so_q;
   assign O_SO_OE                   = is_xfer(state_q) && !cs_prev_q;
   assign O_CMD_DATA                = cmd_q;
   assign O_CMD_VALID               = cmd_valid_q;
   assign O_TRANSMISSION_ERROR_FLAG = ter_q;

   property p_load_on_fall;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (cs_fall && !I_SLEEP) |=> (shift_q == $past(I_RESP_DATA)) && (state_q == ST_XFER);
   endproperty
   a_load_on_fall: assert property (p_load_on_fall) else $error("response not loaded at select fall");

   property p_first_bit;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (cs_fall && !I_SLEEP) |=> (so_q == ($past(ter_q) | $past(core.si_s))) ##1 O_SO_OE;
   endproperty
   a_first_bit: assert property (p_first_bit) else $error("first output bit is not error OR input");

   property p_sleep_float;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (cs_fall && I_SLEEP) |=> (!O_SO_OE && !sclk_fall) throughout (!cs_rise [*2]);
   endproperty
   a_sleep_float: assert property (p_sleep_float) else $error("output driven during sleep");

   property p_idle_float;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (core.cs_n_s && cs_prev_q) |-> !O_SO_OE && !sclk_fall && !sclk_rise && !is_xfer(state_q);
   endproperty
   a_idle_float: assert property (p_idle_float) else $error("activity while deselected");

   property p_shift_in;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (sclk_fall && !cs_fall) |=> (shift_q[0] == $past(core.si_s)) && (shift_q[WORD_BITS-1] == $past(shift_q[WORD_BITS-2]));
   endproperty
   a_shift_in: assert property (p_shift_in) else $error("sample edge did not shift input in");

   property p_shift_out;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (sclk_rise && !lead_q) |=> (so_q == $past(shift_q[WORD_BITS-1]));
   endproperty
   a_shift_out: assert property (p_shift_out) else $error("output did not change on rising clock");

   property p_commit;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      commit |=> O_CMD_VALID && (O_CMD_DATA == $past(shift_q)) ##1 !O_CMD_VALID;
   endproperty
   a_commit: assert property (p_commit) else $error("valid frame not committed");

   property p_reject;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (cs_rise && (state_q == ST_XFER) && !core.frame_ok) |=> O_TRANSMISSION_ERROR_FLAG && !O_CMD_VALID;
   endproperty
   a_reject: assert property (p_reject) else $error("bad frame length not flagged");

   property p_no_stray_commit;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      $rose(O_CMD_VALID) |-> $past(cs_rise) && $past(core.frame_ok);
   endproperty
   a_no_stray_commit: assert property (p_no_stray_commit) else $error("commit without valid frame end");

   property p_lead_bit;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (in_xfer && lead_q) |=> (so_q == ($past(ter_q) | $past(core.si_s)));
   endproperty
   a_lead_bit: assert property (p_lead_bit) else $error("leading output is not error OR input");

   property p_oe_drop;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (cs_rise && is_xfer(state_q)) |=> !O_SO_OE && (state_q == ST_IDLE);
   endproperty
   a_oe_drop: assert property (p_oe_drop) else $error("output still driven after select rise");

   property p_hold_idle;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (!is_xfer(state_q) && !cs_fall) |=> (shift_q == $past(shift_q));
   endproperty
   a_hold_idle: assert property (p_hold_idle) else $error("shifter moved outside a transfer");

   property p_cmd_hold;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      !commit |=> (O_CMD_DATA == $past(O_CMD_DATA)) && !O_CMD_VALID;
   endproperty
   a_cmd_hold: assert property (p_cmd_hold) else $error("command changed without commit");

   // A refused start must end like a bad count: flag raised, nothing committed.
   property p_bad_edge;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (cs_rise && is_xfer(state_q) && (sclk_bad_q || sclk_high_at_cs)) |=> O_TRANSMISSION_ERROR_FLAG && !O_CMD_VALID;
   endproperty
   a_bad_edge: assert property (p_bad_edge) else $error("clock high at select edge not refused");

   property p_blocked_quiet;
      @(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (state_q == ST_BLOCKED) |-> !core.sample && !sclk_rise && !O_SO_OE;
   endproperty
   a_blocked_quiet: assert property (p_blocked_quiet) else $error("transfer activity during sleep");

endmodule : spi_slave_front

`default_nettype wire

// ---- verification/spi_host_model.sv ----
// Behavioural host that drives the serial pins of one slave front end.
// Assumes the slave samples every pin with a much faster clock of its own.
`default_nettype none

module spi_host_model (
   // Pins driven.
   output var logic o_cs_n,
   output var logic o_sclk,
   output var logic o_si,
   // Pins read.
   input  wire logic i_so,
   input  wire logic i_so_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   localparam realtime HALF = 62.5;

   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_si   = 1'b0;
   end

   // The start offset keeps every pin change away from the slave's clock edges.
   task automatic xfer(input int n, input logic [39:0] d, input logic si0,
                       output logic [39:0] rx, output logic so0, output logic [1:0] oe);
      rx = '0;
      oe = 2'b10;
      #3 o_si = si0;
      #HALF o_cs_n = 1'b0;
      #(2*HALF) so0 = i_so;
      o_si = d[n-1];
      for (int i = 0; i < n; i++) begin
         #HALF o_sclk = 1'b1;
         if (i > 0) o_si = d[n-1-i];
         #HALF o_sclk = 1'b0;
         rx[n-1-i] = i_so;
         oe = {oe[1] & i_so_oe, oe[0] | i_so_oe};
      end
      #HALF o_cs_n = 1'b1;
      o_si = ~o_si;
      #(2*HALF);
   endtask : xfer

   // Starts an access with the clock high, which the slave must refuse.
   task automatic bad_start(input int n);
      #3 o_sclk = 1'b1;
      #HALF o_cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         #HALF o_sclk = 1'b0;
         #HALF o_sclk = (i < n - 1);
      end
      o_cs_n = 1'b1;
      #(2*HALF);
   endtask : bad_start

   task automatic noise(input int n);
      #3;
      for (int i = 0; i < 2*n; i++) begin
         #HALF o_sclk = ~o_sclk;
         o_si = ~o_si;
      end
   endtask : noise
endmodule : spi_host_model

`default_nettype wire

// ---- verification/daisy_chain_spi_slave_frontend_tb.sv ----
// Self-checking bench for the serial slave front end with a host model.
// Assumes the package constants and a host model that owns the pins.
`default_nettype none

module daisy_chain_spi_slave_frontend_tb;
   import spi_front_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   logic                 clk   = 1'b0;
   logic                 rst_n = 1'b0;
   logic                 sleep = 1'b0;
   logic                 cs_n, sclk, si, so, so_oe, cmd_valid, err_flag;
   logic [WORD_BITS-1:0] resp  = '0;
   logic [WORD_BITS-1:0] cmd;
   logic [15:0]          exp_cmd = '0;
   logic                 exp_flag = 1'b0;
   int                   num_errors = 0, checked = 0, n_valid = 0, seed = 43;
   int                   lens [10] = '{16, 24, 15, 17, 8, 40, 20, 32, 31, 16};
   wire logic            so_line;

   always #5 clk = ~clk;
   // A released output floats, so an enable that comes late shows up as a mismatch.
   assign so_line = so_oe ? so : 1'bz;
   always @(posedge clk) if (cmd_valid === 1'b1) n_valid <= n_valid + 1;

   spi_slave_front dut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_CHIP_SELECT_N(cs_n), .I_SCLK(sclk),
      .I_SI(si), .O_SO(so), .O_SO_OE(so_oe), .I_SLEEP(sleep), .I_RESP_DATA(resp),
      .O_CMD_DATA(cmd), .O_CMD_VALID(cmd_valid), .O_TRANSMISSION_ERROR_FLAG(err_flag));
   spi_host_model host (.o_cs_n(cs_n), .o_sclk(sclk), .o_si(si), .i_so(so_line), .i_so_oe(so_oe));

   function automatic logic [39:0] lowmask(input int n);
      return (40'h1 << n) - 40'h1;
   endfunction : lowmask

   function automatic logic good_len(input int n);
      return n >= 16 && (n - 16) % 8 == 0;
   endfunction : good_len

   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up

   // Passthrough bits are checked even on refused lengths, since only the commit is dropped.
   task automatic frame(input int n, input logic si0, input logic slp);
      logic [39:0] d, rx;
      logic        so0, ok;
      logic [1:0]  oe;
      int          v0;
      d = 40'({$random(seed), $random(seed)}) & lowmask(n);
      @(posedge clk);
      resp <= 16'($random(seed));
      sleep <= slp;
      @(posedge clk);
      v0 = n_valid;
      ok = good_len(n) && !slp;
      host.xfer(n, d, si0, rx, so0, oe);
      @(posedge clk);
      sleep <= 1'b0;
      if (!slp) begin
         check("so_first", 40'(so0), 40'(exp_flag | si0));
         check("oe_held", 40'(oe[1]), 40'h1);
         if (n >= 16) check("resp", 40'(rx[n-2 -: 15]), 40'(resp[14:0]));
         if (n > 16) check("thru", rx & lowmask(n-16), d >> 16);
         exp_flag = !ok;
      end else
         check("oe_sleep", 40'(oe[0]), 40'h0);
      if (ok) exp_cmd = d[15:0];
      check("valid", 40'(n_valid - v0), 40'(ok));
      check("cmd", 40'(cmd), 40'(exp_cmd));
      check("flag", 40'(err_flag), 40'(exp_flag));
      check("oe_idle", 40'(so_oe), 40'h0);
      $display("frame n=%0d sleep=%0b done", n, slp);
   endtask : frame

   initial begin
      int n;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      check("cmd_rst", 40'(cmd), 40'h0);
      check("flag_rst", 40'(err_flag), 40'h0);
      check("valid_rst", 40'(cmd_valid), 40'h0);
      host.noise(20);
      repeat (8) @(posedge clk);
      check("noise_valid", 40'(n_valid), 40'h0);
      check("noise_oe", 40'(so_oe), 40'h0);
      $display("reset and idle noise done");
      foreach (lens[i]) frame(lens[i], i[0], 1'b0);
      frame(17, 1'b1, 1'b0);
      frame(16, 1'b0, 1'b1);
      n = n_valid;
      @(posedge clk);
      host.bad_start(16);
      @(posedge clk);
      exp_flag = 1'b1;
      check("bad_valid", 40'(n_valid - n), 40'h0);
      check("bad_flag", 40'(err_flag), 40'h1);
      check("bad_cmd", 40'(cmd), 40'(exp_cmd));
      $display("clock-high start done");
      frame(24, 1'b1, 1'b0);
      repeat (20) begin
         n = ($random(seed) & 1) ? 16 + 8 * ($unsigned($random(seed)) % 4) : 9 + $unsigned($random(seed)) % 32;
         frame(n, 1'($random(seed)), 1'(($random(seed) & 7) == 0));
      end
      wrap_up();
   end

   // A whole run needs about an eighth of this span.
   initial begin
      #1000000;
      num_errors++;
      wrap_up();
   end
endmodule : daisy_chain_spi_slave_frontend_tb

`default_nettype wire
